// ===== src/shift4_pkg.sv
// Shared constants and types for the bidirectional shift register
package shift4_pkg;

	// Register geometry and reset contents
	localparam int         STAGE_COUNT  = 4;
	localparam logic [3:0] STAGES_RESET = 4'h0;

	// Trace buffer geometry
	localparam int TRACE_DEPTH = 4;

	// Mode-select codes as {high bit, low bit}
	localparam logic [1:0] CODE_HOLD       = 2'h0;
	localparam logic [1:0] CODE_SHIFT_UP   = 2'h1;
	localparam logic [1:0] CODE_SHIFT_DOWN = 2'h2;
	localparam logic [1:0] CODE_LOAD       = 2'h3;

	// Clock period in ns, kept for reference by timing-aware users
	localparam int CLK_PERIOD_NS = 50;

	// Operating modes decoded from the two select inputs
	typedef enum logic [1:0] {
		MODE_HOLD,
		MODE_SHIFT_UP,
		MODE_SHIFT_DOWN,
		MODE_LOAD
	} mode_e;

endpackage

// ===== src/shift4_reg.sv
// Bidirectional shift register with parallel load and a trace buffer
`timescale 1ns/1ns
`default_nettype none

// Shifting FIFO: head always sits in slot 0, so every output is a flop
module trace_fifo
	import shift4_pkg::*;
#(
	parameter int WIDTH = STAGE_COUNT,
	parameter int DEPTH = TRACE_DEPTH
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             ce,
	input  wire logic             in_valid,
	output var  logic             in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output var  logic             out_valid,
	input  wire logic             out_ready,
	output var  logic [WIDTH-1:0] out_data
);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] data;
		logic [DEPTH-1:0]            used;
		logic                        space;
	} fifo_s;

	fifo_s st;
	fifo_s next_st;

	// Pop first, then push into the lowest free slot of the popped image
	always_comb begin
		logic found;
		found   = 1'b0;
		next_st = st;
		if (out_ready && st.used[0]) begin
			for (int i = 0; i < DEPTH - 1; i++) begin
				next_st.data[i] = st.data[i+1];
				next_st.used[i] = st.used[i+1];
			end
			next_st.data[DEPTH-1] = '0;
			next_st.used[DEPTH-1] = 1'b0;
		end
		// Push only against the registered space flag, so a full buffer really refuses
		if (in_valid && st.space) begin
			for (int i = 0; i < DEPTH; i++) begin
				if (!found && !next_st.used[i]) begin
					next_st.data[i] = in_data;
					next_st.used[i] = 1'b1;
					found           = 1'b1;
				end
			end
		end
		next_st.space = ~next_st.used[DEPTH-1];
	end

	// State register; clock enable freezes the buffer as a whole
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st       <= '0;
			st.space <= 1'b1;
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign in_ready  = st.space;
	assign out_valid = st.used[0];
	assign out_data  = st.data[0];

	// A refused push must leave the occupancy unchanged unless a pop happened
	full_refuse_a: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && in_valid && !st.space && !(out_ready && st.used[0]))
		|=> $stable(st.used))
		else $error("full buffer accepted a word");

	// The head word must survive while nobody drains it
	head_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && st.used[0] && !out_ready) |=> (out_valid && $stable(out_data)))
		else $error("head word changed without a pop");

	// Occupancy stays packed from slot 0, otherwise the head would read a hole
	used_packed_a: assert property (@(posedge clk) disable iff (!rst_n)
		((st.used & (st.used + 1'b1)) == '0))
		else $error("buffer occupancy has a gap");

	// A pop hands the second word to the head on the next edge, keeping order
	pop_advance_a: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && out_ready && st.used[1]) |=> (out_valid && out_data == $past(st.data[1])))
		else $error("pop lost the order of words");

	// A push into an empty buffer shows up at the head one edge later
	push_land_a: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && in_valid && in_ready && !st.used[0]) |=> (out_valid && out_data == $past(in_data)))
		else $error("pushed word did not reach the head");

endmodule

// Top: four-stage register plus a trace of each shifted or loaded word, dropped when the trace is full
module shift4_reg
	import shift4_pkg::*;
#(
	parameter int WIDTH = STAGE_COUNT,
	parameter int DEPTH = TRACE_DEPTH
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             ce,
	input  wire logic             async_clear_n,
	input  wire logic             mode_select_low_bit,
	input  wire logic             mode_select_high_bit,
	input  wire logic             serial_in_toward_high,
	input  wire logic             serial_in_toward_low,
	input  wire logic [WIDTH-1:0] load_inputs,
	output var  logic [WIDTH-1:0] stage_outputs,
	output var  logic             trace_valid,
	input  wire logic             trace_ready,
	output var  logic [WIDTH-1:0] trace_data,
	output var  logic             trace_space,
	output var  logic             trace_dropped
);

	typedef struct packed {
		logic [WIDTH-1:0] stages;
		logic             dropped;
	} reg_s;

	reg_s             st;
	reg_s             next_st;
	mode_e            mode;
	logic             push;
	logic             fifo_space;
	logic [WIDTH-1:0] fifo_data;
	logic             fifo_valid;

	// Mode decode from the two select bits, sampled only at the edge
	always_comb begin
		case ({mode_select_high_bit, mode_select_low_bit})
			CODE_HOLD:       mode = MODE_HOLD;
			CODE_SHIFT_UP:   mode = MODE_SHIFT_UP;
			CODE_SHIFT_DOWN: mode = MODE_SHIFT_DOWN;
			CODE_LOAD:       mode = MODE_LOAD;
			default:         mode = MODE_HOLD;
		endcase
	end

	// Next stage contents; each branch reads only the input its mode needs
	always_comb begin
		next_st = st;
		push    = 1'b0;
		case (mode)
			MODE_HOLD: begin
				next_st.stages = st.stages;
			end
			MODE_SHIFT_UP: begin
				next_st.stages = {st.stages[WIDTH-2:0], serial_in_toward_high};
				push           = 1'b1;
			end
			MODE_SHIFT_DOWN: begin
				next_st.stages = {serial_in_toward_low, st.stages[WIDTH-1:1]};
				push           = 1'b1;
			end
			MODE_LOAD: begin
				next_st.stages = load_inputs;
				push           = 1'b1;
			end
			default: begin
				next_st.stages = st.stages;
			end
		endcase
		// A clear in progress logs nothing, the register is being wiped anyway
		push = push && async_clear_n && ce;
		// Sticky: the trace is advisory, so a full buffer never stalls the register
		if (push && !fifo_space) begin
			next_st.dropped = 1'b1;
		end
	end

	// Clear is asynchronous and wins; rst_n and ce act only on the edge
	// Release of the clear is not aligned to the clock; let go of it away from an edge
	always_ff @(posedge clk or negedge async_clear_n) begin
		if (!async_clear_n) begin
			st <= '0;
		end else if (!rst_n) begin
			st.stages  <= STAGES_RESET;
			st.dropped <= 1'b0;
		end else if (ce) begin
			st <= next_st;
		end
	end

	// Trace buffer holds the word each update produced
	trace_fifo #(
		.WIDTH (WIDTH),
		.DEPTH (DEPTH)
	) u_trace (
		.clk       (clk),
		.rst_n     (rst_n),
		.ce        (ce),
		.in_valid  (push),
		.in_ready  (fifo_space),
		.in_data   (next_st.stages),
		.out_valid (fifo_valid),
		.out_ready (trace_ready),
		.out_data  (fifo_data)
	);

	// Outputs come straight from flops in this module or the buffer
	assign stage_outputs = st.stages;
	assign trace_dropped = st.dropped;
	assign trace_valid   = fifo_valid;
	assign trace_data    = fifo_data;
	assign trace_space   = fifo_space;

	// Mode behaviour checks, one per select code
	hold_keep_a: assert property (
		@(posedge clk) disable iff (!async_clear_n)
		(rst_n && ce && !mode_select_high_bit && !mode_select_low_bit)
		|=> (async_clear_n -> $stable(stage_outputs)))
		else $error("hold mode changed the stages");

	shift_up_a: assert property (
		@(posedge clk) disable iff (!async_clear_n)
		(rst_n && ce && !mode_select_high_bit && mode_select_low_bit)
		|=> (stage_outputs == {$past(stage_outputs[WIDTH-2:0]),
			$past(serial_in_toward_high)}))
		else $error("shift toward stage 3 went wrong");

	shift_down_a: assert property (
		@(posedge clk) disable iff (!async_clear_n)
		(rst_n && ce && mode_select_high_bit && !mode_select_low_bit)
		|=> (stage_outputs == {$past(serial_in_toward_low),
			$past(stage_outputs[WIDTH-1:1])}))
		else $error("shift toward stage 0 went wrong");

	load_all_a: assert property (
		@(posedge clk) disable iff (!async_clear_n)
		(rst_n && ce && mode_select_high_bit && mode_select_low_bit)
		|=> (stage_outputs == $past(load_inputs)))
		else $error("parallel load did not copy all inputs");

	// Edge, enable and clear checks
	edge_only_a: assert property (
		@(posedge clk) disable iff (!async_clear_n)
		(!$stable(stage_outputs)) |-> ($past(ce) || !$past(rst_n)))
		else $error("stages moved without an enabled edge");

	clear_low_a: assert property (
		@(posedge clk)
		(!async_clear_n) |-> (stage_outputs == '0 && !trace_dropped))
		else $error("clear did not force stages low");

	clear_hold_a: assert property (
		@(posedge clk)
		(!async_clear_n && mode_select_high_bit && mode_select_low_bit)
		|=> ((!async_clear_n) -> (stage_outputs == '0)))
		else $error("load overrode an active clear");

	// Trace bookkeeping checks; the trace is advisory, so only its own state is guarded
	trace_log_a: assert property (
		@(posedge clk) disable iff (!rst_n || !async_clear_n)
		(push && fifo_space && !fifo_valid) |=> (trace_valid && trace_data == stage_outputs))
		else $error("trace missed an update");

	drop_flag_a: assert property (
		@(posedge clk) disable iff (!rst_n || !async_clear_n)
		(push && !fifo_space) |=> trace_dropped [*2])
		else $error("overflow not flagged");

	// Synchronous reset empties the register and the overflow flag on the next edge
	reset_state_a: assert property (
		@(posedge clk) disable iff (!async_clear_n)
		(!rst_n) |=> (stage_outputs == STAGES_RESET && !trace_dropped))
		else $error("reset left the register dirty");

	// A low enable freezes the register and the flag whatever the mode inputs say
	ce_freeze_a: assert property (
		@(posedge clk) disable iff (!async_clear_n)
		(rst_n && !ce) |=> ($stable(stage_outputs) && $stable(trace_dropped)))
		else $error("stages moved with the enable low");

	// Once set, the overflow flag stays until a reset or a clear wipes it
	drop_sticky_a: assert property (
		@(posedge clk) disable iff (!rst_n || !async_clear_n)
		trace_dropped |=> trace_dropped)
		else $error("overflow flag fell on its own");

	// A clear must not slip a word into the trace while it wipes the register
	clear_quiet_a: assert property (
		@(posedge clk)
		(rst_n && !async_clear_n && !trace_ready) |=> $stable({trace_valid, trace_space}))
		else $error("clear pushed a word into the trace");

endmodule

`default_nettype wire

// ===== testbench/mode_driver.sv
// Surrounding logic model that drives the mode, serial and parallel inputs
`timescale 1ns/1ns
`default_nettype none
module mode_driver
	import shift4_pkg::*;
(
	input  wire logic       clk,
	output var  logic       mode_select_low_bit,
	output var  logic       mode_select_high_bit,
	output var  logic       serial_in_toward_high,
	output var  logic       serial_in_toward_low,
	output var  logic [3:0] load_inputs
);
	initial begin
		{mode_select_high_bit, mode_select_low_bit} = CODE_HOLD;
		{serial_in_toward_high, serial_in_toward_low, load_inputs} = 6'h00;
	end
	// One operation: inputs settle after an edge and stay put across the next one
	// Back to hold at that edge so the mode is not taken twice
	task automatic step(input logic [1:0] m, input logic u, input logic d, input logic [3:0] l);
		@(posedge clk);
		{mode_select_high_bit, mode_select_low_bit} <= m;
		serial_in_toward_high <= u;
		serial_in_toward_low  <= d;
		load_inputs           <= l;
		@(posedge clk);
		{mode_select_high_bit, mode_select_low_bit} <= CODE_HOLD;
		#1;
	endtask
endmodule
`default_nettype wire

// ===== testbench/shift4_reg_bench.sv
// Self-checking bench for the shift register and its trace buffer
`timescale 1ns/1ns
`default_nettype none
module shift4_reg_bench;
	import shift4_pkg::*;
	logic       clk;
	logic       rst_n;
	logic       ce;
	logic       async_clear_n;
	logic       trace_ready;
	logic       s_lo, s_hi, ser_up, ser_dn;
	logic [3:0] ld, stage, t_data;
	logic       t_valid, t_space, t_drop;
	int         n_errors, total_checks, cycles, n;
	logic [3:0] q[$];

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	mode_driver mode_driver_i (.clk(clk), .mode_select_low_bit(s_lo),
		.mode_select_high_bit(s_hi), .serial_in_toward_high(ser_up),
		.serial_in_toward_low(ser_dn), .load_inputs(ld));

	shift4_reg #(.WIDTH(STAGE_COUNT), .DEPTH(TRACE_DEPTH)) shift4_reg_i (
		.clk(clk), .rst_n(rst_n), .ce(ce), .async_clear_n(async_clear_n),
		.mode_select_low_bit(s_lo), .mode_select_high_bit(s_hi),
		.serial_in_toward_high(ser_up), .serial_in_toward_low(ser_dn),
		.load_inputs(ld), .stage_outputs(stage), .trace_valid(t_valid),
		.trace_ready(trace_ready), .trace_data(t_data), .trace_space(t_space),
		.trace_dropped(t_drop));

	task automatic check(input logic [3:0] seen, input logic [3:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		$display("checks=%0d errors=%0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Hang guard: the sequence needs well under a hundred cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			n_errors++;
			give_verdict();
		end
	end

	initial begin
		{n_errors, total_checks, cycles} = '0;
		{rst_n, ce, async_clear_n, trace_ready} = 4'h6;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		check(stage, 4'h0);
		check({t_valid, t_space, t_drop}, 4'h2);
		// Fill the trace with the sink stalled
		mode_driver_i.step(CODE_LOAD, 1'b0, 1'b0, 4'ha);
		check(stage, 4'ha);
		check(t_data, 4'ha);
		mode_driver_i.step(CODE_SHIFT_UP, 1'b1, 1'b0, 4'h0);
		check(stage, 4'h5);
		mode_driver_i.step(CODE_SHIFT_DOWN, 1'b0, 1'b1, 4'hf);
		check(stage, 4'ha);
		mode_driver_i.step(CODE_HOLD, 1'b1, 1'b1, 4'h3);
		check(stage, 4'ha);
		mode_driver_i.step(CODE_LOAD, 1'b1, 1'b1, 4'h3);
		check(stage, 4'h3);
		q = '{4'ha, 4'h5, 4'ha, 4'h3};
		check({t_space, t_drop}, 4'h0);
		// Full trace: the register still moves, the word is lost
		mode_driver_i.step(CODE_SHIFT_UP, 1'b0, 1'b1, 4'h0);
		check(stage, 4'h6);
		check({t_space, t_drop}, 4'h1);
		// Clock enable low freezes the register
		@(posedge clk);
		ce <= 1'b0;
		mode_driver_i.step(CODE_LOAD, 1'b0, 1'b0, 4'hf);
		check(stage, 4'h6);
		@(posedge clk);
		ce <= 1'b1;
		// Clear acts at once, before any further edge, then under a pending load
		@(posedge clk);
		async_clear_n <= 1'b0;
		#1;
		check(stage, 4'h0);
		mode_driver_i.step(CODE_LOAD, 1'b1, 1'b1, 4'hf);
		check(stage, 4'h0);
		check({t_valid, t_drop}, 4'h2);
		// Drain in order until empty
		@(posedge clk);
		async_clear_n <= 1'b1;
		trace_ready <= 1'b1;
		#1;
		n = 0;
		while (t_valid === 1'b1 && n < 8) begin
			check(t_data, (q.size() > 0) ? q.pop_front() : 4'hx);
			n++;
			@(posedge clk);
			#1;
		end
		check(n[3:0], 4'h4);
		check({t_valid, t_space}, 4'h1);
		// Ring of one: end stages feed the serial inputs as chained neighbours would
		mode_driver_i.step(CODE_LOAD, 1'b0, 1'b0, 4'h9);
		check(stage, 4'h9);
		mode_driver_i.step(CODE_SHIFT_UP, stage[3], 1'b0, 4'h0);
		check(stage, 4'h3);
		mode_driver_i.step(CODE_SHIFT_DOWN, 1'b0, stage[0], 4'h0);
		check(stage, 4'h9);
		give_verdict();
	end
endmodule
`default_nettype wire
